// ---- psn_chk.sv ----
// Assertion checker for the sequence-number engine
`include "psn_regs.vh"
// ==========
// Checks
module psn_chk (
	input wire clock_in,
	input wire rst_in,
	input wire mgmt_reset_req_in,
	input wire mgmt_switch_cmd_in,
	input wire mgmt_ready_out,
	input wire rx_valid_in,
	input wire rx_check_ok_in,
	input wire [`PSN_TYPE_W-1:0] rx_type_in,
	input wire tx_primary_valid_out,
	input wire tx_secondary_valid_out,
	input wire [`PSN_TYPE_W-1:0] tx_type_out,
	input wire tx_has_seq_out,
	input wire ind_rx_accept_out,
	input wire ind_reset_cmd_out,
	input wire ind_reset_recv_out,
	input wire ind_reset_ack_out,
	input wire ind_reset_err_out,
	input wire guard_running_out,
	input wire reply_running_out
);
	timeunit 1ns;
	timeprecision 1ps;
	wire rx_ok = rx_valid_in && rx_check_ok_in;
	default clocking @(posedge clock_in); endclocking
	default disable iff (rst_in);
	property p_dual;
		tx_primary_valid_out == tx_secondary_valid_out;
	endproperty
	a_dual: assert property (p_dual) else $error("links differ");
	property p_cmd;
		ind_reset_cmd_out |-> tx_primary_valid_out && !tx_has_seq_out &&
			tx_type_out == `PSN_MSG_RST_CMD && guard_running_out;
	endproperty
	a_cmd: assert property (p_cmd) else $error("bad reset send");
	property p_recv;
		ind_reset_recv_out |-> tx_primary_valid_out && reply_running_out &&
			tx_type_out == `PSN_MSG_RST_ACK;
	endproperty
	a_recv: assert property (p_recv) else $error("bad reply");
	property p_ack;
		rx_ok && rx_type_in == `PSN_MSG_RST_ACK |=>
			ind_reset_ack_out == $past(guard_running_out);
	endproperty
	a_ack: assert property (p_ack) else $error("ack handling");
	property p_busy;
		rx_ok && rx_type_in == `PSN_MSG_RST_CMD && reply_running_out |=>
			!ind_reset_recv_out;
	endproperty
	a_busy: assert property (p_busy) else $error("reply ran");
	property p_chk;
		rx_valid_in && !rx_check_ok_in |=> !ind_rx_accept_out;
	endproperty
	a_chk: assert property (p_chk) else $error("bad msg taken");
	property p_guard;
		rx_ok && rx_type_in >= `PSN_MSG_SW_CMD && guard_running_out |=>
			!ind_rx_accept_out;
	endproperty
	a_guard: assert property (p_guard) else $error("taken in guard");
	property p_sw_err;
		guard_running_out && mgmt_switch_cmd_in && mgmt_ready_out &&
			!mgmt_reset_req_in |=> ind_reset_err_out && !tx_primary_valid_out;
	endproperty
	a_sw_err: assert property (p_sw_err) else $error("no error");
	c_ack: cover property (ind_reset_ack_out);
	c_err: cover property (ind_reset_err_out);
	c_acc: cover property (ind_rx_accept_out);
endmodule
bind psn_seq_engine psn_chk psn_chk_inst (.*);

// ---- psn_peer.sv ----
// Peer entity model facing the engine's links
`include "psn_regs.vh"
module psn_peer (
	// Clock and bench controls
	input wire clock_in,
	input wire send_in,
	input wire auto_in,
	input wire ok_in,
	input wire [2:0] type_in,
	input wire [6:0] seq_in,
	// Engine's outgoing message
	input wire tx_valid_in,
	input wire [2:0] tx_type_in,
	// Messages toward the engine
	output logic rx_valid_out = 0,
	output logic rx_ok_out = 0,
	output logic [2:0] rx_type_out = 0,
	output logic [6:0] rx_seq_out = 0
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0] send_q = 0;
	// ==========
	// Idle fields toggle so stale values never look valid
	always @(posedge clock_in)
	begin
		rx_valid_out <= 0;
		rx_ok_out <= ~rx_ok_out;
		rx_type_out <= ~rx_type_out;
		rx_seq_out <= ~rx_seq_out;
		if (send_in)
		begin
			// Bench-driven message of any type wins over automatic replies
			rx_valid_out <= 1;
			rx_ok_out <= ok_in;
			rx_type_out <= type_in;
			rx_seq_out <= seq_in;
		end
		else if (auto_in && tx_valid_in && tx_type_in == `PSN_MSG_RST_CMD)
		begin
			rx_valid_out <= 1;
			rx_ok_out <= 1;
			rx_type_out <= `PSN_MSG_RST_ACK;
			send_q <= 0;
		end
		else if (auto_in && tx_valid_in && tx_type_in[2:1] == 2'h1)
		begin
			rx_valid_out <= 1;
			rx_ok_out <= 1;
			rx_type_out <= `PSN_MSG_SW_ACK;
			rx_seq_out <= send_q;
			send_q <= send_q + 7'h01;
		end
	end
endmodule

// ---- psn_regs.vh ----
// Constants of the protection sequence-number engine
`ifndef PSN_REGS_VH
`define PSN_REGS_VH

// ============================================================
// Clock and timer defaults
`define PSN_CLK_MHZ 250
`define PSN_GUARD_TIME_US 1000
`define PSN_REPLY_TIME_US 1000
`define PSN_SWITCH_TIME_US 1000
`define PSN_FORCED_TIME_US 1000

// ============================================================
// Sequence numbering
`define PSN_SEQ_W 7
`define PSN_SEQ_ZERO 7'h00
`define PSN_SEQ_ONE 7'h01
`define PSN_NEW_SPAN 7'h04
`define PSN_DUP_LOW 7'h7b

// ============================================================
// Message type codes
`define PSN_TYPE_W 3
`define PSN_MSG_RST_CMD 3'h0
`define PSN_MSG_RST_ACK 3'h1
`define PSN_MSG_SW_CMD 3'h2
`define PSN_MSG_FORCED_CMD 3'h3
`define PSN_MSG_SW_ACK 3'h4
`define PSN_MSG_SW_REJ 3'h5
`define PSN_MSG_SW_REQ 3'h6

// ============================================================
// Window classes and groups
`define PSN_WIN_NEW 2'h0
`define PSN_WIN_DUP 2'h1
`define PSN_WIN_MIS 2'h2
`define PSN_GROUP_ONE 1'h0

`endif

// ---- psn_seq_engine.v ----
// Exchange-side protection sequence-number and supervision engine
`include "psn_regs.vh"

// Notes on behaviour
// - Awaited acknowledge timed; first expiry resends, second reports error and idles.
// - Every outgoing message goes to both primary and secondary links.
// - Send counter cleared to zero after start-up.
// - Sequenced messages carry send counter, then counter increments modulo 128.
// - Receive counter holds next expected number, cleared after start-up.
// - Numbers receive counter minus 5 to minus 1 are silent duplicates.
// - Numbers receive counter to plus 4 accepted; counter becomes number plus one.
// - Numbers outside both windows start the reset handshake.
// - Error checks pass before any window evaluation.
// - At start-up, once a link is up, a reset request is issued.
// - Initiator sends reset command, clears counters, starts guard timer, indicates.
// - Initiating reset stops switch command timers and returns to idle.
// - Reset command with reply timer idle: acknowledge, clear, start reply timer.
// - Received reset command stops switch supervision and returns to idle.
// - Reset command during reply timer, or its expiry, does nothing.
// - Reset acknowledge stops running guard timer and indicates; else ignored.
// - While guard timer runs, sequenced messages are silently discarded.
// - Switch commands during guard timer get reset error, no state change.
// - First guard expiry resends reset, clears counters, indicates, restarts timer.
// - Second guard expiry reports reset error and stops retrying.
// - Forced switch command never used for protection group 1.
module psn_seq_engine #(
	parameter GUARD_TIME_US = `PSN_GUARD_TIME_US,
	parameter REPLY_TIME_US = `PSN_REPLY_TIME_US,
	parameter SWITCH_TIME_US = `PSN_SWITCH_TIME_US,
	parameter FORCED_TIME_US = `PSN_FORCED_TIME_US
) (
	// Clock and reset
	input wire clock_in,
	input wire rst_in,
	// Link status
	input wire link_primary_up_in,
	input wire link_secondary_up_in,
	// Management primitives
	input wire mgmt_reset_req_in,
	input wire mgmt_switch_cmd_in,
	input wire mgmt_forced_cmd_in,
	input wire mgmt_group_one_in,
	output wire mgmt_ready_out,
	// Received messages
	input wire rx_valid_in,
	input wire rx_check_ok_in,
	input wire [`PSN_TYPE_W-1:0] rx_type_in,
	input wire [`PSN_SEQ_W-1:0] rx_seq_in,
	// Outgoing messages
	output wire tx_primary_valid_out,
	output wire tx_secondary_valid_out,
	output wire [`PSN_TYPE_W-1:0] tx_type_out,
	output wire tx_has_seq_out,
	output wire [`PSN_SEQ_W-1:0] tx_seq_out,
	// Indications
	output wire ind_rx_accept_out,
	output wire ind_reset_cmd_out,
	output wire ind_reset_recv_out,
	output wire ind_reset_ack_out,
	output wire ind_reset_err_out,
	output wire ind_switch_ack_out,
	output wire ind_switch_rej_out,
	output wire ind_switch_err_out,
	// Status
	output wire guard_running_out,
	output wire reply_running_out,
	output wire switch_busy_out
);

	// ============================================================
	// Timing
	localparam [31:0] GUARD_CYC = GUARD_TIME_US * `PSN_CLK_MHZ;
	localparam [31:0] REPLY_CYC = REPLY_TIME_US * `PSN_CLK_MHZ;
	localparam [31:0] SWITCH_CYC = SWITCH_TIME_US * `PSN_CLK_MHZ;
	localparam [31:0] FORCED_CYC = FORCED_TIME_US * `PSN_CLK_MHZ;
	localparam [31:0] CNT_ZERO = 32'h0;
	localparam [31:0] CNT_ONE = 32'h1;
	localparam ST_IDLE = 1'b0;
	localparam ST_INIT = 1'b1;

	// ============================================================
	// Window classification, modulo 128
	function [1:0] seq_window;
		input [`PSN_SEQ_W-1:0] sn;
		input [`PSN_SEQ_W-1:0] vr;
		reg [`PSN_SEQ_W-1:0] diff;
		begin
			diff = sn - vr;
			if (diff <= `PSN_NEW_SPAN)
				seq_window = `PSN_WIN_NEW;
			else if (diff >= `PSN_DUP_LOW)
				seq_window = `PSN_WIN_DUP;
			else
				seq_window = `PSN_WIN_MIS;
		end
	endfunction

	// ============================================================
	// State
	reg state_q, state_d;
	reg forced_q, forced_d;
	reg sw_retry_q, sw_retry_d;
	reg [31:0] sw_cnt_q, sw_cnt_d;
	reg guard_run_q, guard_run_d;
	reg guard_retry_q, guard_retry_d;
	reg [31:0] guard_cnt_q, guard_cnt_d;
	reg reply_run_q, reply_run_d;
	reg [31:0] reply_cnt_q, reply_cnt_d;
	reg [`PSN_SEQ_W-1:0] send_q, send_d;
	reg [`PSN_SEQ_W-1:0] recv_q, recv_d;
	reg startup_q, startup_d;
	reg tx_valid_q, tx_valid_d;
	reg [`PSN_TYPE_W-1:0] tx_type_q, tx_type_d;
	reg tx_has_seq_q, tx_has_seq_d;
	reg [`PSN_SEQ_W-1:0] tx_seq_q, tx_seq_d;
	reg [7:0] ind_q, ind_d;
	reg reset_start;
	reg [1:0] win;

	wire guard_exp = guard_run_q & (guard_cnt_q == CNT_ZERO);
	wire sw_exp = (state_q == ST_INIT) & (sw_cnt_q == CNT_ZERO);
	wire rx_take = rx_valid_in & rx_check_ok_in;
	wire link_up = link_primary_up_in | link_secondary_up_in;
	wire sw_req = mgmt_switch_cmd_in | mgmt_forced_cmd_in;
	// Received messages win, then expiries, then management
	assign mgmt_ready_out = ~rx_valid_in & ~guard_exp & ~sw_exp;

	// ============================================================
	// Next-state logic
	always @*
	begin
		state_d = state_q;
		forced_d = forced_q;
		sw_retry_d = sw_retry_q;
		sw_cnt_d = sw_cnt_q;
		guard_run_d = guard_run_q;
		guard_retry_d = guard_retry_q;
		guard_cnt_d = guard_cnt_q;
		reply_run_d = reply_run_q;
		reply_cnt_d = reply_cnt_q;
		send_d = send_q;
		recv_d = recv_q;
		startup_d = startup_q;
		tx_valid_d = 1'b0;
		tx_type_d = tx_type_q;
		tx_has_seq_d = tx_has_seq_q;
		tx_seq_d = tx_seq_q;
		ind_d = 8'h00;
		reset_start = 1'b0;
		win = seq_window(rx_seq_in, recv_q);
		// Guard and switch timers count down to zero and wait there for service; reply timer stops itself at zero
		if (guard_run_q && guard_cnt_q != CNT_ZERO)
			guard_cnt_d = guard_cnt_q - CNT_ONE;
		if (state_q == ST_INIT && sw_cnt_q != CNT_ZERO)
			sw_cnt_d = sw_cnt_q - CNT_ONE;
		if (reply_run_q)
		begin
			if (reply_cnt_q == CNT_ZERO)
				reply_run_d = 1'b0;
			else
				reply_cnt_d = reply_cnt_q - CNT_ONE;
		end
		if (rx_take)
		begin
			if (rx_type_in == `PSN_MSG_RST_CMD)
			begin
				if (!reply_run_q)
				begin
					tx_valid_d = 1'b1;
					tx_type_d = `PSN_MSG_RST_ACK;
					tx_has_seq_d = 1'b0;
					send_d = `PSN_SEQ_ZERO;
					recv_d = `PSN_SEQ_ZERO;
					reply_run_d = 1'b1;
					reply_cnt_d = REPLY_CYC;
					ind_d[2] = 1'b1;
					state_d = ST_IDLE;
				end
			end
			else if (rx_type_in == `PSN_MSG_RST_ACK)
			begin
				if (guard_run_q)
				begin
					guard_run_d = 1'b0;
					ind_d[3] = 1'b1;
				end
			end
			else if (!guard_run_q)
			begin
				if (win == `PSN_WIN_NEW)
				begin
					recv_d = rx_seq_in + `PSN_SEQ_ONE;
					ind_d[0] = 1'b1;
					if (rx_type_in == `PSN_MSG_SW_ACK)
					begin
						ind_d[5] = 1'b1;
						state_d = ST_IDLE;
					end
					else if (rx_type_in == `PSN_MSG_SW_REJ)
					begin
						ind_d[6] = 1'b1;
						state_d = ST_IDLE;
					end
				end
				else if (win == `PSN_WIN_MIS)
					reset_start = 1'b1;
			end
		end
		else if (guard_exp)
		begin
			if (!guard_retry_q)
			begin
				reset_start = 1'b1;
			end
			else
			begin
				ind_d[4] = 1'b1;
				guard_run_d = 1'b0;
			end
		end
		else if (sw_exp)
		begin
			if (!sw_retry_q)
			begin
				tx_valid_d = 1'b1;
				tx_type_d = forced_q ? `PSN_MSG_FORCED_CMD : `PSN_MSG_SW_CMD;
				tx_has_seq_d = 1'b1;
				tx_seq_d = send_q;
				send_d = send_q + `PSN_SEQ_ONE;
				sw_retry_d = 1'b1;
				sw_cnt_d = forced_q ? FORCED_CYC : SWITCH_CYC;
			end
			else
			begin
				ind_d[7] = 1'b1;
				state_d = ST_IDLE;
			end
		end
		else if (mgmt_reset_req_in || (startup_q && link_up))
		begin
			startup_d = 1'b0;
			reset_start = 1'b1;
		end
		else if (sw_req)
		begin
			if (guard_run_q)
				ind_d[4] = 1'b1;
			else if (state_q == ST_IDLE &&
				!(mgmt_forced_cmd_in && mgmt_group_one_in == `PSN_GROUP_ONE))
			begin
				// Forced commands for group one are dropped
				tx_valid_d = 1'b1;
				tx_type_d = mgmt_forced_cmd_in ? `PSN_MSG_FORCED_CMD
					: `PSN_MSG_SW_CMD;
				tx_has_seq_d = 1'b1;
				tx_seq_d = send_q;
				send_d = send_q + `PSN_SEQ_ONE;
				state_d = ST_INIT;
				forced_d = mgmt_forced_cmd_in;
				sw_retry_d = 1'b0;
				sw_cnt_d = mgmt_forced_cmd_in ? FORCED_CYC : SWITCH_CYC;
			end
		end
		if (reset_start)
		begin
			tx_valid_d = 1'b1;
			tx_type_d = `PSN_MSG_RST_CMD;
			tx_has_seq_d = 1'b0;
			send_d = `PSN_SEQ_ZERO;
			recv_d = `PSN_SEQ_ZERO;
			guard_run_d = 1'b1;
			guard_cnt_d = GUARD_CYC;
			guard_retry_d = guard_exp & ~rx_take;
			ind_d[1] = 1'b1;
			state_d = ST_IDLE;
		end
	end

	// ============================================================
	// Registers
	always @(posedge clock_in)
	begin
		if (rst_in)
		begin
			state_q <= ST_IDLE;
			forced_q <= 1'b0;
			sw_retry_q <= 1'b0;
			sw_cnt_q <= CNT_ZERO;
			guard_run_q <= 1'b0;
			guard_retry_q <= 1'b0;
			guard_cnt_q <= CNT_ZERO;
			reply_run_q <= 1'b0;
			reply_cnt_q <= CNT_ZERO;
			send_q <= `PSN_SEQ_ZERO;
			recv_q <= `PSN_SEQ_ZERO;
			startup_q <= 1'b1;
			tx_valid_q <= 1'b0;
			tx_type_q <= `PSN_MSG_RST_CMD;
			tx_has_seq_q <= 1'b0;
			tx_seq_q <= `PSN_SEQ_ZERO;
			ind_q <= 8'h00;
		end
		else
		begin
			state_q <= state_d;
			forced_q <= forced_d;
			sw_retry_q <= sw_retry_d;
			sw_cnt_q <= sw_cnt_d;
			guard_run_q <= guard_run_d;
			guard_retry_q <= guard_retry_d;
			guard_cnt_q <= guard_cnt_d;
			reply_run_q <= reply_run_d;
			reply_cnt_q <= reply_cnt_d;
			send_q <= send_d;
			recv_q <= recv_d;
			startup_q <= startup_d;
			tx_valid_q <= tx_valid_d;
			tx_type_q <= tx_type_d;
			tx_has_seq_q <= tx_has_seq_d;
			tx_seq_q <= tx_seq_d;
			ind_q <= ind_d;
		end
	end

	// ============================================================
	// Outputs
	assign tx_primary_valid_out = tx_valid_q;
	assign tx_secondary_valid_out = tx_valid_q;
	assign tx_type_out = tx_type_q;
	assign tx_has_seq_out = tx_has_seq_q;
	assign tx_seq_out = tx_seq_q;
	assign ind_rx_accept_out = ind_q[0];
	assign ind_reset_cmd_out = ind_q[1];
	assign ind_reset_recv_out = ind_q[2];
	assign ind_reset_ack_out = ind_q[3];
	assign ind_reset_err_out = ind_q[4];
	assign ind_switch_ack_out = ind_q[5];
	assign ind_switch_rej_out = ind_q[6];
	assign ind_switch_err_out = ind_q[7];
	assign guard_running_out = guard_run_q;
	assign reply_running_out = reply_run_q;
	assign switch_busy_out = state_q;

endmodule

// ---- psn_unused_marker.v ----
// Intentionally empty companion file

// ---- tb_top.sv ----
// Self-checking bench for the sequence-number engine
`include "psn_regs.vh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	// ==========
	// Stimulus and observation
	logic clock_in = 0, rst_in = 1, up = 0, rq = 0, sw = 0, fc = 0;
	logic snd = 0, aut = 1, ko = 1, grp = 0, up2 = 0;
	logic [2:0] st = 0;
	logic [6:0] ss = 0;
	wire rv, rk, tp, ts, hs, ia, ic, ir, ik, ie, gr, rr, sb;
	wire mr, sa, sj, se;
	wire [2:0] rt, tt;
	wire [6:0] rs, tq;
	int n_errors = 0, samples_checked = 0, cyc = 0, c[10];
	always #2 clock_in = ~clock_in;
	psn_seq_engine #(.GUARD_TIME_US(1), .REPLY_TIME_US(1),
		.SWITCH_TIME_US(1), .FORCED_TIME_US(1)) psn_seq_engine_inst (
		.clock_in(clock_in), .rst_in(rst_in), .link_primary_up_in(up),
		.link_secondary_up_in(up2), .mgmt_reset_req_in(rq),
		.mgmt_switch_cmd_in(sw), .mgmt_forced_cmd_in(fc),
		.mgmt_group_one_in(grp), .mgmt_ready_out(mr), .rx_valid_in(rv),
		.rx_check_ok_in(rk), .rx_type_in(rt), .rx_seq_in(rs),
		.tx_primary_valid_out(tp), .tx_secondary_valid_out(ts),
		.tx_type_out(tt), .tx_has_seq_out(hs), .tx_seq_out(tq),
		.ind_rx_accept_out(ia), .ind_reset_cmd_out(ic),
		.ind_reset_recv_out(ir), .ind_reset_ack_out(ik),
		.ind_reset_err_out(ie), .ind_switch_ack_out(sa),
		.ind_switch_rej_out(sj), .ind_switch_err_out(se),
		.guard_running_out(gr), .reply_running_out(rr), .switch_busy_out(sb));
	psn_peer psn_peer_inst (.clock_in(clock_in), .send_in(snd),
		.auto_in(aut), .ok_in(ko), .type_in(st), .seq_in(ss),
		.tx_valid_in(tp), .tx_type_in(tt), .rx_valid_out(rv),
		.rx_ok_out(rk), .rx_type_out(rt), .rx_seq_out(rs));
	// Pulses are counted so single-cycle events are never missed
	always @(posedge clock_in)
	begin
		cyc++;
		c[0] += tp;
		c[1] += ic;
		c[2] += ir;
		c[3] += ik;
		c[4] += ie;
		c[5] += ia;
		c[6] += se;
		c[7] += sj;
		c[8] += sa;
		c[9] += ts;
		if (cyc == 5000)
		begin
			n_errors++;
			conclude;
		end
	end
	task chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task tick(input int n);
		repeat (n) @(posedge clock_in);
		#1;
	endtask
	task mg(input logic [2:0] k);
		@(posedge clock_in);
		{fc, sw, rq} <= k;
		@(posedge clock_in);
		{fc, sw, rq} <= 0;
	endtask
	task px(input logic [2:0] t, input logic [6:0] s, input logic k);
		@(posedge clock_in);
		{snd, st, ss, ko} <= {1'b1, t, s, k};
		@(posedge clock_in);
		snd <= 0;
	endtask
	task t_start;
		tick(5);
		chk(8'(c[0]), 0);
		@(posedge clock_in);
		up <= 1;
		tick(8);
		chk(8'(c[1]), 1);
		chk(8'(c[3]), 1);
		chk(gr, 0);
		chk(mr, 1);
		$display("t_start done");
	endtask
	task t_switch;
		c = '{default: 0};
		for (int i = 0; i < 130; i++)
		begin
			mg(3'h2);
			tick(1);
			chk(tq, 8'(i % 128));
			tick(8);
		end
		chk(8'(c[5]), 130);
		chk(8'(c[8]), 130);
		chk(8'(c[9]), 130);
		chk(sb, 0);
		mg(3'h4);
		tick(3);
		chk(8'(c[0]), 130);
		$display("t_switch done");
	endtask
	task t_window;
		c = '{default: 0};
		px(6, 6, 1);
		#1;
		chk(mr, 0);
		tick(3);
		chk(8'(c[5]), 1);
		px(6, 6, 1);
		tick(3);
		px(6, 2, 1);
		tick(3);
		chk(8'(c[5]), 1);
		px(6, 12, 1);
		tick(7);
		chk(8'(c[1]), 1);
		px(6, 0, 0);
		tick(3);
		chk(8'(c[5]), 1);
		px(6, 0, 1);
		tick(3);
		chk(8'(c[5]), 2);
		$display("t_window done");
	endtask
	task t_guard;
		@(posedge clock_in);
		aut <= 0;
		c = '{default: 0};
		mg(3'h1);
		tick(1);
		chk({gr, hs, tt}, 8'h10);
		mg(3'h2);
		tick(1);
		chk({c[4][3:0], 3'h0, sb}, 8'h10);
		px(6, 0, 1);
		tick(3);
		chk(8'(c[5]), 0);
		tick(250);
		chk(8'(c[1]), 2);
		tick(251);
		chk(8'(c[4]), 2);
		chk(8'(c[0]), 2);
		$display("t_guard done");
	endtask
	task t_reply;
		c = '{default: 0};
		px(0, 0, 1);
		tick(3);
		chk({rr, c[2][3:0], tt}, 8'h89);
		px(0, 0, 1);
		tick(3);
		chk(8'(c[2]), 1);
		$display("t_reply done");
	endtask
	task t_retry;
		c = '{default: 0};
		mg(3'h2);
		tick(1);
		chk({sb, tq}, 8'h80);
		tick(251);
		chk({c[0][3:0], tq[3:0]}, 8'h21);
		tick(251);
		chk({c[6][3:0], c[0][3:0]}, 8'h12);
		chk(sb, 0);
		@(posedge clock_in);
		grp <= 1;
		mg(3'h4);
		tick(1);
		chk({sb, tt, tq[3:0]}, 8'hb2);
		px(5, 0, 1);
		tick(3);
		chk({c[7][3:0], 3'h0, sb}, 8'h10);
		mg(3'h2);
		tick(1);
		mg(3'h1);
		tick(1);
		chk({sb, gr}, 8'h01);
		px(1, 0, 1);
		tick(3);
		chk(gr, 0);
		mg(3'h2);
		tick(1);
		px(0, 0, 1);
		tick(3);
		chk({sb, rr}, 8'h01);
		$display("t_retry done");
	endtask
	task t_restart;
		@(posedge clock_in);
		aut <= 1;
		mg(3'h2);
		tick(4);
		chk({sb, tq}, 8'h00);
		c = '{default: 0};
		@(posedge clock_in);
		{rst_in, up} <= 2'b10;
		tick(4);
		@(posedge clock_in);
		rst_in <= 0;
		tick(5);
		chk({c[0][3:0], c[1][3:0]}, 8'h00);
		mg(3'h2);
		tick(1);
		chk({c[0][3:0], tq[3:0]}, 8'h10);
		tick(4);
		chk(8'(c[5]), 1);
		@(posedge clock_in);
		up2 <= 1;
		tick(6);
		chk(8'(c[1]), 1);
		$display("t_restart done");
	endtask
	task conclude;
		$display("checks %0d errors %0d", samples_checked, n_errors);
		if (n_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge clock_in);
		rst_in <= 0;
		t_start;
		t_switch;
		t_window;
		t_guard;
		t_reply;
		t_retry;
		t_restart;
		conclude;
	end
endmodule
